// >>> diam_pkg.sv
package diam_pkg;
    // ========================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_WSLOT0 = 8'h00; // write slots 1..4 at 00..0C
    localparam logic [7:0] ADDR_RSLOT0 = 8'h10; // read slots 1..4 at 10..1C
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
    localparam logic [7:0] ADDR_ACT_W0 = 8'h30; // active slot map, write side
    localparam logic [7:0] ADDR_ACT_R0 = 8'h34;
    localparam int SLOT_N = 4;
    localparam logic [15:0] SLOT_RESET = 16'h0000;
    // ========================================
    // instance numbers
    localparam logic [7:0] INST_SPD_OUT = 8'd21;
    localparam logic [7:0] INST_SPD_IN = 8'd71;
    localparam logic [7:0] INST_DRV_IN = 8'd101;
    localparam logic [7:0] INST_USR_OUT = 8'd102;
    localparam logic [7:0] INST_USR_IN = 8'd103;
    // ========================================
    // per-unit scale and group type codes
    localparam logic [15:0] PU_FULL_SCALE = 16'd20000;
    localparam logic [7:0] GRP_S = 8'h02;
    localparam logic [7:0] GRP_M = 8'h03;
    localparam logic [7:0] GRP_F = 8'h04;
    localparam logic [7:0] GRP_E = 8'h05;
    localparam logic [7:0] GRP_C = 8'h06;
    localparam logic [7:0] GRP_P = 8'h07;
    localparam logic [7:0] GRP_H = 8'h08;
    localparam logic [7:0] GRP_A = 8'h09;
    localparam logic [7:0] GRP_O = 8'h0A;
    localparam logic [7:0] GRP_J = 8'h0E;
    localparam logic [7:0] GRP_Y = 8'h0F;
    localparam logic [7:0] GRP_W = 8'h10;
    localparam logic [7:0] GRP_X = 8'h11;
    localparam logic [7:0] GRP_Z = 8'h12;
    // ========================================
    // extended speed-control input and output fields
    localparam int SPD_BIT_FAULT = 0;
    localparam int SPD_BIT_RUN_FORWARD = 2;
    localparam int SPD_BIT_RUN_BACKWARD = 3;
    localparam int SPD_BIT_READY = 4;
    localparam int SPD_BIT_CTRL_NET = 5;
    localparam int SPD_BIT_REF_NET = 6;
    localparam int SPD_BIT_AT_REF = 7;
    localparam int SPD_OUT_NET_CTRL = 5;
    localparam int SPD_OUT_NET_REF = 6;
    typedef enum logic [2:0] {
        DIAM_DS_STARTUP = 3'd1,
        DIAM_DS_NOT_READY = 3'd2,
        DIAM_DS_READY = 3'd3,
        DIAM_DS_ENABLED = 3'd4,
        DIAM_DS_STOPPING = 3'd5,
        DIAM_DS_FAULT_STOP = 3'd6,
        DIAM_DS_FAULTED = 3'd7
    } diam_drive_state_t;
    // interrupt status bits
    localparam int IRQ_BIT_PARAM_WR = 0;
    localparam int IRQ_BIT_AT_REF = 1;
    localparam int IRQ_BIT_FAULT = 2;
    localparam int IRQ_W = 3;
endpackage : diam_pkg

// >>> diam_prm_store.sv
`timescale 1ns/1ps
// ========
// parameter store of the inverter core as the card sees it
module diam_prm_store (
    input wire logic clk_i, // system clock
    input wire logic wr_i, // write strobe
    input wire logic [15:0] wr_code_i, // target parameter
    input wire logic [15:0] wr_data_i, // write data
    input wire logic [15:0] rd_code_i, // parameter fetched
    output logic [15:0] rd_data_o, // value, same cycle
    output int wr_cnt_o // writes seen
);
    logic [15:0] mem [0:65535];
    bit seen [0:65535];
    initial wr_cnt_o = 0;
    always @(posedge clk_i) begin
        if (wr_i === 1'b1) begin
            mem[wr_code_i] = wr_data_i;
            seen[wr_code_i] = 1'b1;
            wr_cnt_o = wr_cnt_o + 1;
        end
    end
    // unwritten codes give the inverted code, so a stale or misrouted word stands out
    assign rd_data_o = seen[rd_code_i] ? mem[rd_code_i] : ~rd_code_i;
endmodule : diam_prm_store

// >>> diam_slot_resolve.sv
`timescale 1ns/1ps
// marks each slot valid if its group code is known and no earlier slot already holds the same parameter
module diam_slot_resolve
    import diam_pkg::*;
#(
    parameter int N = SLOT_N
) (
    input wire logic [N*16-1:0] sel_i, // slot selections, slot 0 in low bits
    output logic [N-1:0] valid_o // slot is the effective owner
);
    if (N < 1) begin : g_bad_n
        $error("slot count must be positive");
    end
    // ========================================
    // lowest-numbered slot wins, duplicates treated as unassigned
    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < N; gi++) begin : g_slot
            logic [N-1:0] dup;
            for (gj = 0; gj < N; gj++) begin : g_cmp
                if (gj < gi) begin : g_lo
                    assign dup[gj] = (sel_i[gj*16 +: 16] == sel_i[gi*16 +: 16]);
                end else begin : g_hi
                    assign dup[gj] = 1'b0;
                end
            end
            // a group byte outside the type code table is not a parameter; slot is unassigned
            wire [7:0] grp = sel_i[gi*16+8 +: 8];
            wire known = (grp == GRP_S) || (grp == GRP_M) || (grp == GRP_F) || (grp == GRP_E)
                || (grp == GRP_C) || (grp == GRP_P) || (grp == GRP_H) || (grp == GRP_A)
                || (grp == GRP_O) || (grp == GRP_J) || (grp == GRP_Y) || (grp == GRP_W)
                || (grp == GRP_X) || (grp == GRP_Z);
            assign valid_o[gi] = known && (dup == '0);
        end
    endgenerate
endmodule : diam_slot_resolve

// >>> diam_top.sv
`timescale 1ns/1ps
// Summary of operation
// - instance 101 byte 0: forward, backward, dc braking, shut down, braking, bus ok, torque, voltage.
// - byte 1: current, accel, decel, fault, network enabled, reserved, access fault, busy.
// - bus ok flag is one while link voltage is up, zero on undervoltage.
// - bytes 2-3 hold output frequency per unit, max frequency equals 20000, low first.
// - instance 102 has four words, low byte first; word n writes write slot n target.
// - duplicate parameter selections: only lowest slot acts, others unassigned.
// - instance 103 has four words, low byte first; word n reads read slot n target.
// - slot value: upper byte group code, lower byte parameter number in binary.
// - group codes S=02 through Z=12 as tabulated.
// - slot changes act only after inverter and card restart.
// - at-reference bit set only once speed reached; cleared while accelerating.
// - stopped and ready under network control reports 70 03 00 00.
// - drive state field uses 1 startup through 7 faulted.
module diam_top
    import diam_pkg::*;
#(
    parameter int N = SLOT_N
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    // wishbone slave
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic irq_o, // level interrupt
    // inverter core status
    input wire logic [7:0] drv_flags0_i, // flags, bit order as packed
    input wire logic [7:0] drv_flags1_i, // flags, bit 5 ignored
    input wire logic [15:0] out_freq_pu_i, // output frequency, 20000 = max
    input wire logic [15:0] speed_act_i, // actual speed r/min
    input wire logic [15:0] speed_ref_i, // commanded speed r/min
    input wire logic [2:0] drive_state_i, // drive state code
    input wire logic ready_i, // drive ready
    input wire logic faulted_i, // tripped
    input wire logic run_forward_i, // running forward
    input wire logic run_backward_i, // running backward
    input wire logic accel_i, // accelerating
    input wire logic restart_i, // card and inverter restart pulse
    // fieldbus side
    input wire logic [63:0] out_asm_i, // output assembly bytes, byte 0 low
    input wire logic out_asm_vld_i, // output assembly received pulse
    output logic [63:0] in_asm_o, // input assembly bytes, byte 0 low
    // parameter access to inverter core
    output logic [15:0] prm_wr_code_o, // selected parameter of write
    output logic [15:0] prm_wr_data_o, // write data
    output logic prm_wr_o, // write strobe
    output logic [15:0] prm_rd_code_o, // parameter being fetched
    input wire logic [15:0] prm_rd_data_i, // value of prm_rd_code_o, same cycle
    output logic net_ctrl_req_o, // network run source requested
    output logic net_ref_req_o // network speed source requested
);
    // the packing below is written out for exactly four slots
    if (N != SLOT_N) begin : g_bad_n
        $error("assembly layout serves exactly four slots");
    end
    // ========================================
    // configuration registers
    logic [15:0] wsel_reg [N];
    logic [15:0] rsel_reg [N];
    logic [15:0] wact_reg [N]; // settings in force since last restart
    logic [15:0] ract_reg [N];
    logic [7:0] out_inst_reg;
    logic [7:0] in_inst_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [N-1:0] wval;
    logic [N-1:0] rval;
    logic [N*16-1:0] wflat;
    logic [N*16-1:0] rflat;
    genvar gk;
    generate
        for (gk = 0; gk < N; gk++) begin : g_flat
            assign wflat[gk*16 +: 16] = wact_reg[gk];
            assign rflat[gk*16 +: 16] = ract_reg[gk];
        end
    endgenerate
    diam_slot_resolve #(.N(N)) u_wres (.sel_i(wflat), .valid_o(wval));
    diam_slot_resolve #(.N(N)) u_rres (.sel_i(rflat), .valid_o(rval));
    // ========================================
    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [5:0] widx = wb_adr_i[7:2];
    wire hit_wslot = (wb_adr_i >= ADDR_WSLOT0) && (wb_adr_i < ADDR_RSLOT0);
    wire hit_rslot = (wb_adr_i >= ADDR_RSLOT0) && (wb_adr_i < ADDR_CTRL);
    wire [1:0] slot_idx = widx[1:0];
    logic [31:0] rd_mux;
    wire [31:0] status_word = {16'h0000, 5'h00, drive_state_i, faulted_i, ready_i, 6'h00};
    wire [31:0] act_w_word = {28'h0000000, wval};
    wire [31:0] act_r_word = {28'h0000000, rval};
    always_comb begin
        if (hit_wslot) begin
            rd_mux = {16'h0000, wsel_reg[slot_idx]};
        end else if (hit_rslot) begin
            rd_mux = {16'h0000, rsel_reg[slot_idx]};
        end else if (wb_adr_i == ADDR_CTRL) begin
            rd_mux = {16'h0000, in_inst_reg, out_inst_reg};
        end else if (wb_adr_i == ADDR_STATUS) begin
            rd_mux = status_word;
        end else if (wb_adr_i == ADDR_IRQ_STAT) begin
            rd_mux = {29'h00000000, irq_stat_reg};
        end else if (wb_adr_i == ADDR_IRQ_MASK) begin
            rd_mux = {29'h00000000, irq_mask_reg};
        end else if (wb_adr_i == ADDR_ACT_W0) begin
            rd_mux = act_w_word;
        end else if (wb_adr_i == ADDR_ACT_R0) begin
            rd_mux = act_r_word;
        end else begin
            rd_mux = 32'h00000000; // unmapped reads zero, still acked
        end
    end
    // ========================================
    // slot selections; new values wait for restart before use
    genvar gs;
    generate
        for (gs = 0; gs < N; gs++) begin : g_slotreg
            wire wr_w = bus_wr && hit_wslot && (slot_idx == gs);
            wire wr_r = bus_wr && hit_rslot && (slot_idx == gs);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    wsel_reg[gs] <= SLOT_RESET;
                    rsel_reg[gs] <= SLOT_RESET;
                end else begin
                    if (wr_w) begin
                        wsel_reg[gs] <= (wsel_reg[gs] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                    end
                    if (wr_r) begin
                        rsel_reg[gs] <= (rsel_reg[gs] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                    end
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    wact_reg[gs] <= SLOT_RESET;
                    ract_reg[gs] <= SLOT_RESET;
                end else if (restart_i) begin
                    wact_reg[gs] <= wsel_reg[gs];
                    ract_reg[gs] <= rsel_reg[gs];
                end
            end
        end
    endgenerate
    // ========================================
    // control, interrupt and bus answer registers
    logic [IRQ_W-1:0] irq_ev;
    wire [IRQ_W-1:0] irq_clr = (bus_wr && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) ?
        wb_dat_i[IRQ_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_inst_reg <= INST_SPD_OUT;
            in_inst_reg <= INST_SPD_IN;
            irq_mask_reg <= '0;
            irq_stat_reg <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            irq_o <= 1'b0;
        end else begin
            if (bus_wr && wb_adr_i == ADDR_CTRL) begin
                if (wb_sel_i[0]) begin
                    out_inst_reg <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    in_inst_reg <= wb_dat_i[15:8];
                end
            end
            if (bus_wr && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
            end
            // a new event beats a simultaneous clear
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
            irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_ev) & irq_mask_reg);
        end
    end
    // ========================================
    // output assembly: user-defined write slots
    logic [1:0] wr_ptr_reg;
    logic wr_busy_reg;
    logic [63:0] out_hold_reg;
    wire wr_take = wr_busy_reg && wval[wr_ptr_reg];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= 2'd0;
            wr_busy_reg <= 1'b0;
            out_hold_reg <= 64'h0000000000000000;
            prm_wr_o <= 1'b0;
            prm_wr_code_o <= 16'h0000;
            prm_wr_data_o <= 16'h0000;
        end else begin
            prm_wr_o <= wr_take;
            if (wr_take) begin
                prm_wr_code_o <= wact_reg[wr_ptr_reg];
                prm_wr_data_o <= out_hold_reg[{wr_ptr_reg, 4'h0} +: 16];
            end
            if (out_asm_vld_i && out_inst_reg == INST_USR_OUT) begin
                out_hold_reg <= out_asm_i;
                wr_busy_reg <= 1'b1;
                wr_ptr_reg <= 2'd0;
            end else if (wr_busy_reg) begin
                wr_ptr_reg <= wr_ptr_reg + 2'd1;
                if (wr_ptr_reg == 2'(N - 1)) begin
                    wr_busy_reg <= 1'b0;
                end
            end
        end
    end
    // ========================================
    // network source requests from the extended output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            net_ctrl_req_o <= 1'b0;
            net_ref_req_o <= 1'b0;
        end else if (out_asm_vld_i && out_inst_reg == INST_SPD_OUT) begin
            net_ctrl_req_o <= out_asm_i[SPD_OUT_NET_CTRL];
            net_ref_req_o <= out_asm_i[SPD_OUT_NET_REF];
        end
    end
    // ========================================
    // input assembly: user-defined read slots, polled round robin
    logic [1:0] rd_ptr_reg;
    logic [15:0] rd_word_reg [N];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr_reg <= 2'd0;
            prm_rd_code_o <= 16'h0000;
        end else begin
            rd_ptr_reg <= rd_ptr_reg + 2'd1;
            prm_rd_code_o <= ract_reg[rd_ptr_reg + 2'd1];
        end
    end
    genvar gr;
    generate
        for (gr = 0; gr < N; gr++) begin : g_rdword
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    rd_word_reg[gr] <= 16'h0000;
                end else if (!rval[gr]) begin
                    rd_word_reg[gr] <= 16'h0000;
                end else if (rd_ptr_reg == gr) begin
                    rd_word_reg[gr] <= prm_rd_data_i;
                end
            end
        end
    endgenerate
    // ========================================
    // status packing
    wire at_ref = (speed_act_i == speed_ref_i) && !accel_i
        && (run_forward_i || run_backward_i);
    // bit 1 stays zero: the extended status has no use for it
    wire [7:0] spd_b0 = {at_ref, net_ref_req_o, net_ctrl_req_o, ready_i,
        run_backward_i, run_forward_i, 1'b0, faulted_i};
    wire [63:0] spd_word = {32'h00000000, speed_act_i, 5'h00, drive_state_i, spd_b0};
    wire [7:0] drv_b1 = {drv_flags1_i[7:6], 1'b0, drv_flags1_i[4:0]};
    wire [63:0] drv_word = {32'h00000000, out_freq_pu_i, drv_b1, drv_flags0_i};
    wire [63:0] usr_word = {rd_word_reg[3], rd_word_reg[2], rd_word_reg[1], rd_word_reg[0]};
    logic [63:0] in_next;
    always_comb begin
        if (in_inst_reg == INST_DRV_IN) begin
            in_next = drv_word;
        end else if (in_inst_reg == INST_USR_IN) begin
            in_next = usr_word;
        end else begin
            in_next = spd_word;
        end
    end
    logic at_ref_d_reg;
    logic fault_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_asm_o <= 64'h0000000000000000;
            at_ref_d_reg <= 1'b0;
            fault_d_reg <= 1'b0;
        end else begin
            in_asm_o <= in_next;
            at_ref_d_reg <= at_ref;
            fault_d_reg <= faulted_i;
        end
    end
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_BIT_PARAM_WR] = wr_take;
        irq_ev[IRQ_BIT_AT_REF] = at_ref && !at_ref_d_reg;
        irq_ev[IRQ_BIT_FAULT] = faulted_i && !fault_d_reg;
    end
    // ========================================
    // checks
    chk_spd_atref_accel: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_SPD_IN && accel_i && $stable(in_inst_reg))
            |=> !in_asm_o[SPD_BIT_AT_REF])
        else $error("at-reference set while accelerating");
    // layout checks per selected instance
    chk_drv_flag_bytes: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_DRV_IN) |=> (in_asm_o[7:0] == $past(drv_flags0_i)))
        else $error("drive flag byte wrong");
    chk_usr_word_top: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_USR_IN) |=> (in_asm_o[63:48] == $past(rd_word_reg[3])))
        else $error("read word 4 misplaced");
    chk_state_field: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_SPD_IN) |=> (in_asm_o[10:8] == $past(drive_state_i)))
        else $error("drive state field wrong");
    chk_net_src_update: assert property (@(posedge clk_i) disable iff (rst_i)
        (out_asm_vld_i && out_inst_reg == INST_SPD_OUT)
            |=> (net_ctrl_req_o == $past(out_asm_i[SPD_OUT_NET_CTRL])))
        else $error("network run source not updated");
    chk_unassigned_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_busy_reg && !wval[wr_ptr_reg]) |=> !prm_wr_o)
        else $error("unassigned write word not ignored");
    chk_drv_freq_word: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_DRV_IN) |=> (in_asm_o[31:16] == $past(out_freq_pu_i)))
        else $error("frequency word wrong");
    chk_drv_reserved_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(in_inst_reg) == INST_DRV_IN |-> !in_asm_o[13])
        else $error("reserved bit set");
    chk_usr_unassigned_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rval[0] && $stable(rval)) |=> (rd_word_reg[0] == 16'h0000))
        else $error("unassigned read word not zero");
    chk_wr_strobe_valid: assert property (@(posedge clk_i) disable iff (rst_i)
        prm_wr_o |-> $past(wval[wr_ptr_reg]))
        else $error("write issued for unassigned slot");
    chk_wr_word_map: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take |=> (prm_wr_data_o == $past(out_hold_reg[{wr_ptr_reg, 4'h0} +: 16])))
        else $error("write word mismatch");
    chk_slot_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        !restart_i |=> $stable(wact_reg[0]) && $stable(ract_reg[0]))
        else $error("slot setting applied without restart");
    chk_spd_ready_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_inst_reg == INST_SPD_IN && ready_i && !run_forward_i && !run_backward_i
            && !faulted_i && net_ctrl_req_o && net_ref_req_o && drive_state_i == DIAM_DS_READY
            && speed_act_i == 16'h0000) ##1 $stable(in_inst_reg)
            |-> in_asm_o[31:0] == 32'h00000370)
        else $error("ready idle status wrong");
    chk_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : diam_top

// >>> diam_top_tb_top.sv
`timescale 1ns/1ps
module diam_top_tb_top;
    import diam_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, irq_o, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, drv_flags0_i = 8'h00, drv_flags1_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [15:0] out_freq_pu_i = 16'h0, speed_act_i = 16'h0, speed_ref_i = 16'h0;
    logic [2:0] drive_state_i = 3'h0;
    logic ready_i = 1'b0, faulted_i = 1'b0, run_forward_i = 1'b0, run_backward_i = 1'b0;
    logic accel_i = 1'b0, restart_i = 1'b0, out_asm_vld_i = 1'b0;
    logic [63:0] out_asm_i = 64'h0, in_asm_o;
    logic [15:0] prm_wr_code_o, prm_wr_data_o, prm_rd_code_o, prm_rd_data_i;
    logic prm_wr_o, net_ctrl_req_o, net_ref_req_o;
    int wr_cnt;
    int num_errors = 0, checks_done = 0, cycles = 0;
    logic [7:0] grp [14] = '{GRP_S, GRP_M, GRP_F, GRP_E, GRP_C, GRP_P, GRP_H, GRP_A,
        GRP_O, GRP_J, GRP_Y, GRP_W, GRP_X, GRP_Z};
    always #5 clk_i = ~clk_i;
    diam_top #(.N(SLOT_N)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .drv_flags0_i(drv_flags0_i), .drv_flags1_i(drv_flags1_i), .out_freq_pu_i(out_freq_pu_i),
        .speed_act_i(speed_act_i), .speed_ref_i(speed_ref_i), .drive_state_i(drive_state_i),
        .ready_i(ready_i), .faulted_i(faulted_i), .run_forward_i(run_forward_i),
        .run_backward_i(run_backward_i), .accel_i(accel_i), .restart_i(restart_i), .out_asm_i(out_asm_i),
        .out_asm_vld_i(out_asm_vld_i), .in_asm_o(in_asm_o), .prm_wr_code_o(prm_wr_code_o),
        .prm_wr_data_o(prm_wr_data_o), .prm_wr_o(prm_wr_o), .prm_rd_code_o(prm_rd_code_o),
        .prm_rd_data_i(prm_rd_data_i), .net_ctrl_req_o(net_ctrl_req_o),
        .net_ref_req_o(net_ref_req_o));
    diam_prm_store u_prm (.clk_i(clk_i), .wr_i(prm_wr_o), .wr_code_i(prm_wr_code_o),
        .wr_data_i(prm_wr_data_o), .rd_code_i(prm_rd_code_o), .rd_data_o(prm_rd_data_i),
        .wr_cnt_o(wr_cnt));
    // ========
    // shared tasks
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, adr, d, r);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        chk(what, {32'h0, exp}, {32'h0, r});
    endtask : rdchk
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic send(input logic [63:0] d);
        @(posedge clk_i);
        out_asm_i <= d;
        out_asm_vld_i <= 1'b1;
        @(posedge clk_i);
        out_asm_vld_i <= 1'b0;
        settle(8);
    endtask : send
    // hangs are cut here; the whole run needs well under 2000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ========
    // scenarios
    initial begin
        logic [15:0] c0, c1, w0, w1;
        int k;
        int g;
        void'($urandom(32'h1AA5));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("slot reset", ADDR_RSLOT0, 32'h0);
        rdchk("unmapped", 8'hFC, 32'h0);
        for (k = 0; k < 14; k++) begin
            c0 = {grp[k], 8'($urandom)};
            wr(ADDR_WSLOT0 + 8'(4 * (k % 4)), {16'h0, c0});
            rdchk("slot value", ADDR_WSLOT0 + 8'(4 * (k % 4)), {16'h0, c0});
        end
        wr(ADDR_CTRL, 32'h6566);
        for (k = 0; k < 6; k++) begin
            @(posedge clk_i);
            drv_flags0_i <= (k == 0) ? 8'h20 : 8'($urandom);
            drv_flags1_i <= (k == 0) ? 8'hFF : 8'($urandom);
            out_freq_pu_i <= (k == 0) ? PU_FULL_SCALE : 16'($urandom_range(20000));
            settle(2);
            chk("drive status", {32'h0, out_freq_pu_i, drv_flags1_i & 8'hDF, drv_flags0_i},
                in_asm_o);
        end
        // slot 4 repeats slot 1's parameter and must lose to it
        g = $urandom_range(13);
        c0 = {grp[g], 8'($urandom)};
        c1 = {grp[(g + 1) % 14], 8'h1A};
        w0 = 16'($urandom);
        w1 = 16'($urandom);
        wr(ADDR_WSLOT0, {16'h0, c0});
        wr(ADDR_WSLOT0 + 8'h04, {16'h0, c1});
        wr(ADDR_WSLOT0 + 8'h08, 32'h0);
        wr(ADDR_WSLOT0 + 8'h0C, {16'h0, c0});
        wr(ADDR_RSLOT0, {16'h0, c1});
        wr(ADDR_RSLOT0 + 8'h04, 32'h0);
        wr(ADDR_RSLOT0 + 8'h08, {16'h0, c0});
        wr(ADDR_RSLOT0 + 8'h0C, {16'h0, c1});
        send({~w0, 16'h55AA, w1, w0});
        chk("writes before restart", 64'd0, 64'(wr_cnt));
        @(posedge clk_i);
        restart_i <= 1'b1;
        @(posedge clk_i);
        restart_i <= 1'b0;
        send({~w0, 16'h55AA, w1, w0});
        chk("write count", 64'd2, 64'(wr_cnt));
        chk("slot 1 target", {48'h0, w0}, {48'h0, u_prm.mem[c0]});
        chk("slot 2 target", {48'h0, w1}, {48'h0, u_prm.mem[c1]});
        rdchk("active write map", ADDR_ACT_W0, 32'h3);
        rdchk("event status", ADDR_IRQ_STAT, 32'h1);
        chk("masked irq", 64'h0, {63'h0, irq_o});
        wr(ADDR_CTRL, 32'h6766);
        settle(12);
        chk("user input", {16'h0, w0, 16'h0, w1}, in_asm_o);
        // extended speed control: stopped, ready, network control
        wr(ADDR_IRQ_MASK, 32'h2);
        wr(ADDR_CTRL, 32'h4715);
        @(posedge clk_i);
        ready_i <= 1'b1;
        drive_state_i <= DIAM_DS_READY;
        speed_ref_i <= 16'h0708;
        send(64'h0708_0060);
        chk("net sources", 64'h3, {62'h0, net_ctrl_req_o, net_ref_req_o});
        chk("ready input", 64'h0000_0370, in_asm_o);
        rdchk("status reg", ADDR_STATUS, 32'h0340);
        @(posedge clk_i);
        run_forward_i <= 1'b1;
        accel_i <= 1'b1;
        drive_state_i <= DIAM_DS_ENABLED;
        speed_act_i <= 16'h0708;
        settle(3);
        chk("accelerating input", 64'h0708_0474, in_asm_o);
        chk("irq before reference", 64'h0, {63'h0, irq_o});
        @(posedge clk_i);
        accel_i <= 1'b0;
        settle(3);
        chk("at reference input", 64'h0708_04F4, in_asm_o);
        chk("irq at reference", 64'h1, {63'h0, irq_o});
        wr(ADDR_IRQ_STAT, 32'h7);
        rdchk("cleared status", ADDR_IRQ_STAT, 32'h0);
        settle(2);
        chk("irq after clear", 64'h0, {63'h0, irq_o});
        // trip while at reference, and hand the speed source back to the drive
        @(posedge clk_i);
        faulted_i <= 1'b1;
        drive_state_i <= DIAM_DS_FAULTED;
        send(64'h0708_0021);
        chk("fault input", 64'h0708_07B5, in_asm_o);
        chk("net sources", 64'h2, {62'h0, net_ctrl_req_o, net_ref_req_o});
        rdchk("fault event", ADDR_IRQ_STAT, 32'h4);
        tally_and_finish();
    end
endmodule : diam_top_tb_top
